// [sample_buffer.sv]
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Small flip-flop FIFO with valid/ready on both sides
module sample_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt;
  logic [PW-1:0]    rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0]    count_r, count_nxt;
  logic             not_full_r, not_full_nxt;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    push       = in_valid && not_full_r;
    pop        = out_ready && (count_r != '0);
    mem_nxt    = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = in_data;
      wr_ptr_nxt        = ptr_inc(wr_ptr_r);
    end
    if (pop) begin
      rd_ptr_nxt = ptr_inc(rd_ptr_r);
    end
    if (push && !pop) begin
      count_nxt = CW'(count_r + 1'b1);
    end else if (pop && !push) begin
      count_nxt = CW'(count_r - 1'b1);
    end
    // Ready is registered so the source sees a clean flop output
    not_full_nxt = (count_nxt != CW'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      not_full_r <= 1'b1;
    end else begin
      mem_r      <= mem_nxt;
      wr_ptr_r   <= wr_ptr_nxt;
      rd_ptr_r   <= rd_ptr_nxt;
      count_r    <= count_nxt;
      not_full_r <= not_full_nxt;
    end
  end

  assign in_ready  = not_full_r;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign level     = count_r;

endmodule // sample_buffer

// [monitor_pwm_out.sv]
// Contract
// - Rx and tx contributions scaled by own attenuation.
// - Zero attenuation mutes that path entirely.
// - Attenuation touches monitor output only.
// - Mode bits 5:4 choose delta-sigma, RZ, balanced PWM.

`timescale 1ns/100ps

package monitor_pkg;

  // Bus geometry
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int SAMPLE_W = 16;
  localparam int ATT_W    = 8;

  // Register indices; byte address is four times the index
  localparam int IDX_WAVE_CTRL = 1;
  localparam int IDX_IRQ_CTRL  = 2;
  localparam int IDX_ATT_RX    = 20;
  localparam int IDX_ATT_TX    = 21;
  localparam int IDX_STATUS    = 24;
  localparam logic [ADDR_W-1:0] ADDR_WAVE_CTRL = ADDR_W'(IDX_WAVE_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL  = ADDR_W'(IDX_IRQ_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_ATT_RX    = ADDR_W'(IDX_ATT_RX * 4);
  localparam logic [ADDR_W-1:0] ADDR_ATT_TX    = ADDR_W'(IDX_ATT_TX * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = ADDR_W'(IDX_STATUS * 4);

  // Field positions
  localparam int PWM_EN_BIT   = 3;
  localparam int MODE_LSB     = 4;
  localparam int MODE_MSB     = 5;
  localparam int IRQ_EN_BIT   = 7;
  localparam int ST_PIN_BIT   = 0;
  localparam int ST_MODE_LSB  = 1;
  localparam int ST_LEVEL_LSB = 4;

  // Reset values
  localparam logic [7:0] WAVE_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RST  = 8'h00;
  localparam logic [7:0] ATT_RST       = 8'h00;

  // Responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_HZ         = 25_000_000;
  localparam int PWM_HZ         = 32_000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam int CNT_W          = $clog2(PWM_PERIOD_CYC);
  localparam int BUF_DEPTH      = 2;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] rx;
    logic signed [SAMPLE_W-1:0] tx;
  } sample_s;

  typedef enum {WAVE_DSM, WAVE_RZ, WAVE_BAL, WAVE_OFF} wave_e;
  typedef enum {REG_WAVE, REG_IRQ, REG_ATT_RX, REG_ATT_TX, REG_STATUS, REG_NONE} reg_e;

endpackage

////////////////////////////////////////////////////////////////////////////////
module monitor_pwm_out #(
  parameter int PERIOD_CYC = monitor_pkg::PWM_PERIOD_CYC,
  parameter int BUF_DEPTH  = monitor_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                                CLOCK,
  input  wire logic                                RSTN,
  // Write address and data
  input  wire logic                                AWVALID,
  output logic                                     AWREADY,
  input  wire logic [monitor_pkg::ADDR_W-1:0]      AWADDR,
  input  wire logic                                WVALID,
  output logic                                     WREADY,
  input  wire logic [monitor_pkg::DATA_W-1:0]      WDATA,
  input  wire logic [monitor_pkg::DATA_W/8-1:0]    WSTRB,
  // Write response
  output logic                                     BVALID,
  input  wire logic                                BREADY,
  output logic [1:0]                               BRESP,
  // Read address and data
  input  wire logic                                ARVALID,
  output logic                                     ARREADY,
  input  wire logic [monitor_pkg::ADDR_W-1:0]      ARADDR,
  output logic                                     RVALID,
  input  wire logic                                RREADY,
  output logic [monitor_pkg::DATA_W-1:0]           RDATA,
  output logic [1:0]                               RRESP,
  // Audio sample stream
  input  wire logic                                SAMPLE_VALID,
  output logic                                     SAMPLE_READY,
  input  wire monitor_pkg::sample_s                SAMPLE_DATA,
  // Monitor pin
  output logic                                     MONITOR_OUT_PIN
);

  localparam int CW = $clog2(PERIOD_CYC);
  localparam int LW = $clog2(BUF_DEPTH+1);
  localparam int SW = monitor_pkg::SAMPLE_W;
  localparam int AW = monitor_pkg::ATT_W;

  function automatic monitor_pkg::reg_e decode(input logic [monitor_pkg::ADDR_W-1:0] a);
    case (a)
      monitor_pkg::ADDR_WAVE_CTRL: decode = monitor_pkg::REG_WAVE;
      monitor_pkg::ADDR_IRQ_CTRL:  decode = monitor_pkg::REG_IRQ;
      monitor_pkg::ADDR_ATT_RX:    decode = monitor_pkg::REG_ATT_RX;
      monitor_pkg::ADDR_ATT_TX:    decode = monitor_pkg::REG_ATT_TX;
      monitor_pkg::ADDR_STATUS:    decode = monitor_pkg::REG_STATUS;
      default:                     decode = monitor_pkg::REG_NONE;
    endcase
  endfunction

  function automatic monitor_pkg::wave_e to_wave(input logic [1:0] m);
    case (m)
      2'h0:    to_wave = monitor_pkg::WAVE_DSM;
      2'h1:    to_wave = monitor_pkg::WAVE_RZ;
      2'h2:    to_wave = monitor_pkg::WAVE_BAL;
      default: to_wave = monitor_pkg::WAVE_OFF;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  typedef enum {WR_COLLECT, WR_RESP} wr_e;

  wr_e                         wr_state_r, wr_state_nxt;
  logic                        aw_held_r, aw_held_nxt;
  logic                        w_held_r, w_held_nxt;
  logic [monitor_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [7:0]                  wbyte_r, wbyte_nxt;
  logic                        wlane_r, wlane_nxt;
  logic                        awready_r, awready_nxt;
  logic                        wready_r, wready_nxt;
  logic                        bvalid_r, bvalid_nxt;
  logic [1:0]                  bresp_r, bresp_nxt;
  logic                        arready_r, arready_nxt;
  logic                        rvalid_r, rvalid_nxt;
  logic [monitor_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0]                  rresp_r, rresp_nxt;
  logic [7:0]                  wave_ctrl_r, wave_ctrl_nxt;
  logic [7:0]                  irq_ctrl_r, irq_ctrl_nxt;
  logic [AW-1:0]               att_r [2];
  logic [AW-1:0]               att_nxt [2];
  logic [7:0]                  status;
  monitor_pkg::reg_e           wsel;

  always_comb begin
    wr_state_nxt  = wr_state_r;
    aw_held_nxt   = aw_held_r;
    w_held_nxt    = w_held_r;
    awaddr_nxt    = awaddr_r;
    wbyte_nxt     = wbyte_r;
    wlane_nxt     = wlane_r;
    bvalid_nxt    = bvalid_r;
    bresp_nxt     = bresp_r;
    wave_ctrl_nxt = wave_ctrl_r;
    irq_ctrl_nxt  = irq_ctrl_r;
    att_nxt       = att_r;
    wsel          = decode(awaddr_r);
    if (AWVALID && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = AWADDR;
    end
    if (WVALID && wready_r) begin
      w_held_nxt = 1'b1;
      wbyte_nxt  = WDATA[7:0];
      wlane_nxt  = WSTRB[0];
    end
    case (wr_state_r)
      WR_COLLECT: begin
        if (aw_held_r && w_held_r) begin
          wr_state_nxt = WR_RESP;
          aw_held_nxt  = 1'b0;
          w_held_nxt   = 1'b0;
          bvalid_nxt   = 1'b1;
          bresp_nxt    = (wsel == monitor_pkg::REG_NONE) ? monitor_pkg::RESP_SLVERR
                                                         : monitor_pkg::RESP_OKAY;
          // Only the low byte carries data; other lanes are ignored
          if (wlane_r) begin
            case (wsel)
              monitor_pkg::REG_WAVE:   wave_ctrl_nxt = wbyte_r;
              monitor_pkg::REG_IRQ:    irq_ctrl_nxt  = wbyte_r;
              monitor_pkg::REG_ATT_RX: att_nxt[0]    = wbyte_r;
              monitor_pkg::REG_ATT_TX: att_nxt[1]    = wbyte_r;
              default:                 wave_ctrl_nxt = wave_ctrl_r;
            endcase
          end
        end
      end
      WR_RESP: begin
        if (BREADY) begin
          wr_state_nxt = WR_COLLECT;
          bvalid_nxt   = 1'b0;
        end
      end
      default: wr_state_nxt = WR_COLLECT;
    endcase
    awready_nxt = !aw_held_nxt && (wr_state_nxt == WR_COLLECT);
    wready_nxt  = !w_held_nxt && (wr_state_nxt == WR_COLLECT);
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && RREADY) begin
      rvalid_nxt = 1'b0;
    end else if (ARVALID && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = monitor_pkg::RESP_OKAY;
      case (decode(ARADDR))
        monitor_pkg::REG_WAVE:   rdata_nxt = {24'h000000, wave_ctrl_r};
        monitor_pkg::REG_IRQ:    rdata_nxt = {24'h000000, irq_ctrl_r};
        monitor_pkg::REG_ATT_RX: rdata_nxt = {24'h000000, att_r[0]};
        monitor_pkg::REG_ATT_TX: rdata_nxt = {24'h000000, att_r[1]};
        monitor_pkg::REG_STATUS: rdata_nxt = {24'h000000, status};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = monitor_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wr_state_r  <= WR_COLLECT;
      aw_held_r   <= 1'b0;
      w_held_r    <= 1'b0;
      awaddr_r    <= '0;
      wbyte_r     <= 8'h00;
      wlane_r     <= 1'b0;
      awready_r   <= 1'b0;
      wready_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= monitor_pkg::RESP_OKAY;
      arready_r   <= 1'b0;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h00000000;
      rresp_r     <= monitor_pkg::RESP_OKAY;
      wave_ctrl_r <= monitor_pkg::WAVE_CTRL_RST;
      irq_ctrl_r  <= monitor_pkg::IRQ_CTRL_RST;
      att_r[0]    <= monitor_pkg::ATT_RST;
      att_r[1]    <= monitor_pkg::ATT_RST;
    end else begin
      wr_state_r  <= wr_state_nxt;
      aw_held_r   <= aw_held_nxt;
      w_held_r    <= w_held_nxt;
      awaddr_r    <= awaddr_nxt;
      wbyte_r     <= wbyte_nxt;
      wlane_r     <= wlane_nxt;
      awready_r   <= awready_nxt;
      wready_r    <= wready_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      arready_r   <= arready_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
      wave_ctrl_r <= wave_ctrl_nxt;
      irq_ctrl_r  <= irq_ctrl_nxt;
      att_r       <= att_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffer; a late frame tick stalls the source, never drops
  logic                 buf_valid;
  logic                 buf_ready;
  logic [2*SW-1:0]      buf_data;
  logic [LW-1:0]        buf_level;
  monitor_pkg::sample_s head;

  sample_buffer #(
    .WIDTH (2*SW),
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .clk       (CLOCK),
    .rst_n     (RSTN),
    .in_valid  (SAMPLE_VALID),
    .in_ready  (SAMPLE_READY),
    .in_data   (SAMPLE_DATA),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data),
    .level     (buf_level)
  );

  assign head = monitor_pkg::sample_s'(buf_data);

  ////////////////////////////////////////////////////////////////////////////
  // Mixing: linear gain att/256, zero gives exact silence
  logic signed [SW+AW:0] scaled [2];
  logic signed [SW-1:0]  path   [2];
  logic signed [SW+AW+1:0] mix_sum;
  logic signed [SW+1:0]  mix_shr;
  logic signed [SW-1:0]  mix_sat;

  assign path[0] = head.rx;
  assign path[1] = head.tx;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_path
      assign scaled[g] = path[g] * $signed({1'b0, att_r[g]});
    end
  endgenerate

  always_comb begin
    mix_sum = (SW+AW+2)'(scaled[0]) + (SW+AW+2)'(scaled[1]);
    mix_shr = (SW+2)'(mix_sum >>> AW);
    if (mix_shr > (SW+2)'(32767)) begin
      mix_sat = 16'h7FFF;
    end else if (mix_shr < -(SW+2)'(32768)) begin
      mix_sat = 16'h8000;
    end else begin
      mix_sat = mix_shr[SW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform generation; line-facing samples are never altered here
  monitor_pkg::wave_e   wave;
  logic                 pin_en;
  logic [CW-1:0]        cnt_r, cnt_nxt;
  logic [SW-1:0]        level_r, level_nxt;
  logic [CW-1:0]        duty_r, duty_nxt;
  logic [SW-1:0]        acc_r, acc_nxt;
  logic                 pin_r, pin_nxt;
  logic                 frame_end;
  logic [SW-1:0]        new_level;
  logic [SW+CW-1:0]     duty_prod;
  logic [CW-1:0]        bal_lo;

  assign wave      = to_wave(wave_ctrl_r[monitor_pkg::MODE_MSB:monitor_pkg::MODE_LSB]);
  // Pin serves the monitor only with irq output off and pwm on
  assign pin_en    = wave_ctrl_r[monitor_pkg::PWM_EN_BIT] && !irq_ctrl_r[monitor_pkg::IRQ_EN_BIT];
  assign frame_end = (cnt_r == CW'(PERIOD_CYC-1));
  assign buf_ready = frame_end;
  // Underrun keeps the previous level rather than clicking to zero
  assign new_level = buf_valid ? (mix_sat ^ 16'h8000) : level_r;
  // A power-of-two period does not fit CW bits, so widen before use
  assign duty_prod = new_level * (SW+CW)'(PERIOD_CYC);
  assign bal_lo    = CW'(((CW+1)'(PERIOD_CYC) - (CW+1)'(duty_r)) >> 1);

  always_comb begin
    cnt_nxt   = frame_end ? '0 : CW'(cnt_r + 1'b1);
    level_nxt = frame_end ? new_level : level_r;
    duty_nxt  = frame_end ? duty_prod[SW+CW-1:SW] : duty_r;
    acc_nxt   = acc_r;
    pin_nxt   = 1'b0;
    if (pin_en) begin
      case (wave)
        monitor_pkg::WAVE_DSM: begin
          {pin_nxt, acc_nxt} = {1'b0, acc_r} + {1'b0, level_r};
        end
        monitor_pkg::WAVE_RZ: begin
          pin_nxt = (cnt_r < duty_r);
        end
        monitor_pkg::WAVE_BAL: begin
          pin_nxt = (cnt_r >= bal_lo) && (cnt_r < CW'(bal_lo + duty_r));
        end
        default: pin_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_r   <= '0;
      level_r <= 16'h8000;
      duty_r  <= '0;
      acc_r   <= '0;
      pin_r   <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      level_r <= level_nxt;
      duty_r  <= duty_nxt;
      acc_r   <= acc_nxt;
      pin_r   <= pin_nxt;
    end
  end

  assign status = {
    2'b00,
    2'(buf_level),
    2'(wave_ctrl_r[monitor_pkg::MODE_MSB:monitor_pkg::MODE_LSB]),
    pin_en,
    pin_r
  };

  assign AWREADY         = awready_r;
  assign WREADY          = wready_r;
  assign BVALID          = bvalid_r;
  assign BRESP           = bresp_r;
  assign ARREADY         = arready_r;
  assign RVALID          = rvalid_r;
  assign RDATA           = rdata_r;
  assign RRESP           = rresp_r;
  assign MONITOR_OUT_PIN = pin_r;

endmodule // monitor_pwm_out

// [monitor_pwm_out_checker.sv]
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module monitor_pwm_out_checker #(
  parameter int PERIOD_CYC = monitor_pkg::PWM_PERIOD_CYC,
  parameter int BUF_DEPTH  = monitor_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic                           CLOCK,
  input wire logic                           RSTN,
  // Register bus
  input wire logic                           AWVALID,
  input wire logic                           AWREADY,
  input wire logic [monitor_pkg::ADDR_W-1:0] AWADDR,
  input wire logic                           WVALID,
  input wire logic                           WREADY,
  input wire logic [monitor_pkg::DATA_W-1:0] WDATA,
  input wire logic                           BVALID,
  input wire logic                           BREADY,
  input wire logic [1:0]                     BRESP,
  input wire logic                           ARVALID,
  input wire logic                           ARREADY,
  input wire logic                           RVALID,
  input wire logic                           RREADY,
  input wire logic [monitor_pkg::DATA_W-1:0] RDATA,
  input wire logic [1:0]                     RRESP,
  // Stream and pin
  input wire logic                           SAMPLE_VALID,
  input wire logic                           SAMPLE_READY,
  input wire logic                           MONITOR_OUT_PIN
);
  logic [7:0] aw_r, aw_nxt, wd_r, wd_nxt, ctl_r, ctl_nxt, irq_r, irq_nxt;
  logic       bv_r;
  logic       drive_ok;

  // Mirror of control writes; lags the commit by one cycle, hence the margin below
  always_comb begin
    aw_nxt   = (AWVALID && AWREADY) ? AWADDR : aw_r;
    wd_nxt   = (WVALID && WREADY) ? WDATA[7:0] : wd_r;
    ctl_nxt  = (BVALID && !bv_r && aw_r == monitor_pkg::ADDR_WAVE_CTRL) ? wd_r : ctl_r;
    irq_nxt  = (BVALID && !bv_r && aw_r == monitor_pkg::ADDR_IRQ_CTRL) ? wd_r : irq_r;
    drive_ok = ctl_r[monitor_pkg::PWM_EN_BIT] && !irq_r[monitor_pkg::IRQ_EN_BIT]
               && ctl_r[monitor_pkg::MODE_MSB:monitor_pkg::MODE_LSB] != 2'h3;
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      {aw_r, wd_r, ctl_r, irq_r, bv_r} <= '0;
    end else begin
      {aw_r, wd_r, ctl_r, irq_r, bv_r} <= {aw_nxt, wd_nxt, ctl_nxt, irq_nxt, BVALID};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  a_write_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  a_read_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  a_read_busy: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while busy");
  a_write_busy: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  a_unmapped_zero: assert property (RVALID && RRESP == monitor_pkg::RESP_SLVERR |-> RDATA == 0)
    else $error("error read returned data");
  a_buffer_full: assert property ($fell(SAMPLE_READY) |-> $past(SAMPLE_VALID))
    else $error("stream ready fell without a push");
  a_pin_idle: assert property (!drive_ok [*3] |-> !MONITOR_OUT_PIN)
    else $error("pin driven while output disabled");
endmodule // monitor_pwm_out_checker

bind monitor_pwm_out monitor_pwm_out_checker #(
  .PERIOD_CYC(PERIOD_CYC), .BUF_DEPTH(BUF_DEPTH)
) chk_u (
  .CLOCK(CLOCK), .RSTN(RSTN), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
  .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .BVALID(BVALID), .BREADY(BREADY),
  .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
  .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .SAMPLE_VALID(SAMPLE_VALID),
  .SAMPLE_READY(SAMPLE_READY), .MONITOR_OUT_PIN(MONITOR_OUT_PIN)
);

// [speaker_model.sv]
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Speaker behind the transistor; an unknown drive counts as silent
module speaker_model (
  // Clock
  input wire logic clk,
  // Drive and window control
  input wire logic drive,
  input wire logic clear,
  // Driven cycles since the last clear
  output int       high_cycles
);
  always @(posedge clk) begin
    if (clear) begin
      high_cycles <= 0;
    end else begin
      high_cycles <= high_cycles + ((drive === 1'b1) ? 1 : 0);
    end
  end
endmodule // speaker_model

// [call_progress_audio_pwm_out_test.sv]
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module call_progress_audio_pwm_out_test;
  // Short frame keeps the run brief
  localparam int P = 16;
  logic CLOCK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, SAMPLE_VALID, clr;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SAMPLE_READY, MONITOR_OUT_PIN;
  logic [7:0]           AWADDR, ARADDR, ar, at;
  logic [31:0]          WDATA, RDATA, rd;
  logic [3:0]           WSTRB;
  logic [1:0]           BRESP, RRESP, rsp;
  logic signed [15:0]   rx, tx;
  monitor_pkg::sample_s SAMPLE_DATA;
  int err_total, n_compared, cycles, hi, seed, e;

  monitor_pwm_out #(.PERIOD_CYC(P), .BUF_DEPTH(2)) dut_u (
    .CLOCK(CLOCK), .RSTN(RSTN), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID),
    .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY),
    .SAMPLE_DATA(SAMPLE_DATA), .MONITOR_OUT_PIN(MONITOR_OUT_PIN)
  );
  speaker_model spk_u (.clk(CLOCK), .drive(MONITOR_OUT_PIN), .clear(clr), .high_cycles(hi));

  initial begin
    CLOCK = 1'h0;
    forever #20 CLOCK = ~CLOCK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      give_verdict();
    end
  end

  // Address and data offered together, each dropped once taken; ready stays high
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    AWADDR <= a; WDATA <= d; AWVALID <= 1'h1; WVALID <= 1'h1; BREADY <= 1'h1;
    forever begin
      @(posedge CLOCK);
      if (AWVALID && AWREADY) AWVALID <= 1'h0;
      if (WVALID && WREADY) WVALID <= 1'h0;
      if (BVALID && BREADY) break;
    end
    r = BRESP;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ARADDR <= a; ARVALID <= 1'h1; RREADY <= 1'h1;
    forever begin
      @(posedge CLOCK);
      if (ARVALID && ARREADY) ARVALID <= 1'h0;
      if (RVALID && RREADY) break;
    end
    d = RDATA; r = RRESP;
  endtask

  // Host setup: wave control, irq enable, both attenuations, then one frame sample
  task automatic setup(input logic [1:0] m, input logic en, input logic irq);
    wr(monitor_pkg::ADDR_WAVE_CTRL, {26'h0, m, en, 3'h0}, rsp);
    wr(monitor_pkg::ADDR_IRQ_CTRL, {24'h0, irq, 7'h0}, rsp);
    wr(monitor_pkg::ADDR_ATT_RX, {24'h0, ar}, rsp);
    wr(monitor_pkg::ADDR_ATT_TX, {24'h0, at}, rsp);
    // Payload may change only after an accepting edge
    while (!SAMPLE_READY) @(posedge CLOCK);
    SAMPLE_DATA <= {rx, tx};
    repeat (4 * P) @(posedge CLOCK);
    clr <= 1'h1;
    @(posedge CLOCK);
    clr <= 1'h0;
    repeat (8 * P + 1) @(posedge CLOCK);
  endtask

  // Offset-binary level of the saturated mix
  function automatic int level_of(input int r, input int t, input int a, input int b);
    int m;
    m = (r * a + t * b) >>> 8;
    if (m > 32767) m = 32767;
    if (m < -32768) m = -32768;
    return m + 32768;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, SAMPLE_VALID, clr} = '0;
    {AWADDR, ARADDR, WDATA, SAMPLE_DATA, ar, at, rx, tx} = '0;
    WSTRB = 4'hF;
    cycles = 0;
    seed = 32'h043CD9BD;
    repeat (12) @(posedge CLOCK);
    RSTN <= 1'h1;
    repeat (2) @(posedge CLOCK);
    for (int i = 0; i < 4; i++) begin
      rdr(8'(32'h0408_5054 >> (8 * (3 - i))), rd, rsp);
      check(rd, 32'h0000_0000);
      check(rsp, monitor_pkg::RESP_OKAY);
    end
    wr(monitor_pkg::ADDR_ATT_TX, 32'hFFFF_F1AB, rsp);
    rdr(monitor_pkg::ADDR_ATT_TX, rd, rsp);
    check(rd, 32'h0000_00AB);
    check(rsp, monitor_pkg::RESP_OKAY);
    wr(8'hFC, 32'h0000_00FF, rsp);
    check(rsp, monitor_pkg::RESP_SLVERR);
    rdr(8'hFC, rd, rsp);
    check(rd, 32'h0000_0000);
    check(rsp, monitor_pkg::RESP_SLVERR);
    SAMPLE_VALID <= 1'h1;
    for (int i = 0; i < 12; i++) begin
      rx = $random(seed);
      tx = $random(seed);
      ar = (i == 0 || i == 3) ? 8'h00 : $random(seed);
      at = (i == 0 || i == 4) ? 8'h00 : $random(seed);
      if (i == 5) {rx, tx, ar, at} = {16'h7FFF, 16'h7FFF, 8'hFF, 8'hFF};
      setup(i % 3, 1'h1, 1'h0);
      e = level_of(rx, tx, ar, at);
      if (i % 3 == 0) check(hi >= (e * 8 * P) / 65536 - 1 && hi <= (e * 8 * P) / 65536 + 1, 1);
      else check(hi, 8 * ((e * P) >> 16));
    end
    // Source held valid: ready opens exactly once per frame
    e = 0;
    repeat (P) begin
      @(posedge CLOCK);
      e += SAMPLE_READY;
    end
    check(e, 1);
    {rx, tx, ar, at} = {16'h4000, 16'h4000, 8'h80, 8'h80};
    setup(2'h3, 1'h1, 1'h0);
    check(hi, 0);
    setup(2'h1, 1'h0, 1'h0);
    check(hi, 0);
    setup(2'h1, 1'h1, 1'h1);
    check(hi, 0);
    while (!SAMPLE_READY) @(posedge CLOCK);
    SAMPLE_VALID <= 1'h0;
    repeat (3 * P) @(posedge CLOCK);
    check(SAMPLE_READY, 1'h1);
    give_verdict();
  end
endmodule // call_progress_audio_pwm_out_test
